// File: eeprom_write_guard_bulk_ops_tb.sv
`timescale 1ns/1ps
`include "ewg_defs.svh"
// ==========================================================================
// Bench: lock, unlock, refusals and both bulk operations.
// ==========================================================================
module eeprom_write_guard_bulk_ops_tb;
	localparam int TEW = 20; // Shortened self-timed pulse.
	logic        clk, rst_b, ce, cs, sk, di, pe, dout, doe, unl, busy, oe_s, do_s;
	logic [9:0]  peek_addr;
	logic [15:0] peek_data;
	int          err_count = 0;
	int          tests_run = 0;
	ewg_guard #(.TEW_CYC(TEW)) i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .chip_select(cs),
		.serial_clock_in(sk), .serial_data_in(di), .program_enable_input(pe),
		.peek_addr(peek_addr), .peek_data(peek_data), .serial_data_out(dout),
		.serial_data_oe(doe), .write_unlocked(unl), .bulk_busy(busy));
	ewg_host i_host (.clk(clk), .serial_data_out(dout), .serial_data_oe(doe),
		.chip_select(cs), .serial_clock_in(sk), .serial_data_in(di),
		.program_enable_input(pe));
	// Compares one value and counts the result.
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Builds a frame without data for one extension code.
	function automatic logic [12:0] cmd(input logic [1:0] ext);
		return {1'b1, `EWG_OPC_EXT, ext, 8'h00};
	endfunction
	// Polls the status and checks it against the expected level.
	task automatic poll_chk(input logic exp);
		i_host.poll(oe_s, do_s);
		chk("status_oe", 16'h0001, {15'h0000, oe_s});
		chk("status", {15'h0000, exp}, {15'h0000, do_s});
	endtask
	// Reads the array at four places, first and last word included, and checks each word.
	task automatic peek_all(input logic [15:0] exp);
		for (int a = 0; a < 1024; a += 341)
		begin
			peek_addr = a[9:0];
			i_host.tick(2);
			chk("peek_data", exp, peek_data);
		end
	endtask
	// Runs one permitted bulk operation through to its end.
	task automatic t_bulk(input logic [28:0] bits, input int n, input logic [15:0] exp);
		i_host.send(bits, n);
		chk("busy_start", 16'h0001, {15'h0000, busy});
		poll_chk(1'b0);
		for (int i = 0; i < TEW + 1200 && busy; i++)
			i_host.tick(1);
		if (busy !== 1'b0)
		begin
			chk("busy_end", 16'h0000, {15'h0000, busy});
			summarize();
		end
		poll_chk(1'b1);
		peek_all(exp);
		chk("unlocked", 16'h0001, {15'h0000, unl});
	endtask
	// Refused bulk work: nothing starts and the status reads ready.
	task automatic t_refused(input logic [28:0] bits, input int n);
		i_host.send(bits, n);
		chk("busy_refused", 16'h0000, {15'h0000, busy});
		poll_chk(1'b1);
	endtask
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Main sequence: every scenario in turn.
	initial
	begin
		rst_b = 1'b0;
		ce = 1'b1;
		peek_addr = 10'h000;
		repeat (2) @(posedge clk);
		#1 rst_b = 1'b1;
		chk("unlocked", 16'h0000, {15'h0000, unl});
		t_refused({16'h0000, cmd(`EWG_EXT_BCLEAR)}, 13);
		i_host.send({16'h0000, cmd(`EWG_EXT_UNLOCK)}, 13);
		chk("unlocked", 16'h0001, {15'h0000, unl});
		i_host.set_pe(1'b0);
		t_refused({cmd(`EWG_EXT_BPROG), 16'h1234}, 29);
		i_host.set_pe(1'b1);
		t_bulk({cmd(`EWG_EXT_BPROG), 16'hA5C3}, 29, 16'hA5C3);
		t_bulk({16'h0000, cmd(`EWG_EXT_BCLEAR)}, 13, 16'hFFFF);
		t_bulk({cmd(`EWG_EXT_BPROG), 16'h0F0F}, 29, 16'h0F0F);
		// Mid-run reset after unlocking: the latch must come back locked.
		i_host.tick(1);
		rst_b = 1'b0;
		i_host.tick(2);
		rst_b = 1'b1;
		chk("unlocked", 16'h0000, {15'h0000, unl});
		t_refused({16'h0000, cmd(`EWG_EXT_BCLEAR)}, 13);
		i_host.send({16'h0000, cmd(`EWG_EXT_UNLOCK)}, 13);
		chk("unlocked", 16'h0001, {15'h0000, unl});
		i_host.send({16'h0000, cmd(`EWG_EXT_LOCK)}, 13);
		chk("unlocked", 16'h0000, {15'h0000, unl});
		t_refused({cmd(`EWG_EXT_BPROG), 16'h0000}, 29);
		peek_all(16'h0F0F);
		summarize();
	end
endmodule // eeprom_write_guard_bulk_ops_tb

// File: ewg_array.sv
`timescale 1ns/1ps
`include "ewg_defs.svh"

// ==========================================================================
// Memory array with a registered read port and a bulk fill sweep port.
// ==========================================================================
module ewg_array #(
	parameter int ADDR_W = `EWG_ADDR_W,
	parameter int DATA_W = `EWG_DATA_W
) (
	input  wire logic              clk,
	input  wire logic              ce,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [DATA_W-1:0] wr_data,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [DATA_W-1:0] rd_data
);

	// Storage words.
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	// Write one word and register the read word.
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			if (wr_en)
			begin
				mem[wr_addr] <= wr_data;
			end
			rd_data <= mem[rd_addr];
		end
	end

endmodule // ewg_array

// File: ewg_defs.svh
`ifndef EWG_DEFS_SVH
`define EWG_DEFS_SVH

// ==========================================================================
// Instruction shape
// ==========================================================================

// Width of the opcode field after the start bit.
`define EWG_OPC_W        2
// Width of the address field.
`define EWG_ADDR_W       10
// Width of the data word.
`define EWG_DATA_W       16
// Total bits after the start bit for a bulk program frame.
`define EWG_FRAME_BITS   28
// Bits after the start bit for a frame without data.
`define EWG_CMD_BITS     12

// ==========================================================================
// Opcode and address prefixes
// ==========================================================================

// Two-bit opcode that carries the extended group.
`define EWG_OPC_EXT      2'h0
// Two-bit extension held in the top address bits.
`define EWG_EXT_LOCK     2'h0
`define EWG_EXT_BPROG    2'h1
`define EWG_EXT_BCLEAR   2'h2
`define EWG_EXT_UNLOCK   2'h3

// ==========================================================================
// Timing
// ==========================================================================

// Self-timed program or clear pulse width in microseconds.
`define EWG_TEW_US       5000
// Clock rate in MHz.
`define EWG_CLK_MHZ      125
// Cycles of the self-timed pulse.
`define EWG_TEW_CYC      (`EWG_TEW_US * `EWG_CLK_MHZ)

`endif

// File: ewg_guard.sv
`timescale 1ns/1ps
`include "ewg_defs.svh"

// Overview of operation
// R1 - Latch locked after power-up reset
// R2 - Host unlocks before any program or clear
// R3 - Unlock persists until lock or reset
// R4 - Locked: program and clear refused
// R5 - Reads allowed whether locked or not
// R6 - Host deselects after clear instruction
// R7 - Chip-select fall starts bulk clear
// R8 - Cleared array reads all ones
// R9 - Host sends program opcode, word, deselects
// R10 - Chip-select fall starts bulk program
// R11 - Bulk program overwrites any prior content
// R12 - Bulk cycle needs no serial clock
// R13 - Selected during cycle: output shows status
// R14 - Output low busy, high ready
// R15 - Bulk work needs program enable high
// R16 - Host frames start, opcode, address, data
// R17 - Host honours minimum deselect time
// R18 - Refused bulk starts nothing, polls ready
module ewg_guard #(
	parameter int TEW_CYC = `EWG_TEW_CYC,
	parameter int ADDR_W  = `EWG_ADDR_W,
	parameter int DATA_W  = `EWG_DATA_W
) (
	input  wire logic              clk,
	input  wire logic              rst_b,
	input  wire logic              ce,
	input  wire logic              chip_select,
	input  wire logic              serial_clock_in,
	input  wire logic              serial_data_in,
	input  wire logic              program_enable_input,
	input  wire logic [ADDR_W-1:0] peek_addr,
	output logic      [DATA_W-1:0] peek_data,
	output logic                   serial_data_out,
	output logic                   serial_data_oe,
	output logic                   write_unlocked,
	output logic                   bulk_busy
);

	// ======================================================================
	// Pin synchronisers
	// ======================================================================

	// First and second stages for chip select, clock, data and enable.
	logic [3:0] sync1;
	logic [3:0] sync2;
	// Previous synchronised levels, for edge detection.
	logic       cs_prev;
	logic       sk_prev;

	// Two flops before any logic sees a pin.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end
		else if (ce)
		begin
			sync1 <= {program_enable_input, serial_data_in, serial_clock_in, chip_select};
			sync2 <= sync1;
		end
	end

	// Synchronised levels; a floating enable pin is pulled high outside.
	wire cs_s = sync2[0];
	wire sk_s = sync2[1];
	wire di_s = sync2[2];
	wire pe_s = sync2[3];
	// Edge strobes on the synchronised levels.
	wire cs_rise = cs_s & ~cs_prev;
	wire cs_fall = ~cs_s & cs_prev;
	wire sk_rise = sk_s & ~sk_prev;

	// ======================================================================
	// Frame receiver
	// ======================================================================

	// Receiver and engine state.
	ewg_pkg::ewg_state_t state;
	ewg_pkg::ewg_state_t next_state;
	// Shift register for the bits after the start bit.
	logic [`EWG_FRAME_BITS-1:0] shreg;
	// Count of bits taken after the start bit.
	logic [4:0]                 bit_cnt;
	// Armed bulk operation and its data word.
	ewg_pkg::ewg_op_t           armed_op;
	// Latch state: one means program and clear are permitted while the enable pin is high.
	logic                       unlocked;
	// Self-timed cycle counter.
	logic [31:0]                tew_cnt;
	// Sweep address during the bulk fill.
	logic [ADDR_W-1:0]          sweep;
	logic [DATA_W-1:0]          fill_word;

	// Field decode of the frame taken so far.
	wire [1:0] opc     = shreg[`EWG_CMD_BITS-1 -: `EWG_OPC_W];
	wire [1:0] ext     = shreg[`EWG_CMD_BITS-3 -: 2];
	wire [1:0] opc_d   = shreg[`EWG_FRAME_BITS-1 -: `EWG_OPC_W];
	wire [1:0] ext_d   = shreg[`EWG_FRAME_BITS-3 -: 2];
	wire       cmd_done  = (bit_cnt == 5'(`EWG_CMD_BITS));
	wire       data_done = (bit_cnt == 5'(`EWG_FRAME_BITS));
	wire       is_ext    = cmd_done && (opc == `EWG_OPC_EXT);
	wire       is_bprog  = data_done && (opc_d == `EWG_OPC_EXT) && (ext_d == `EWG_EXT_BPROG);
	// Bulk work permitted only when unlocked and enabled. [R4] [R15]
	wire       may_write = unlocked & pe_s;
	wire       tew_end   = (tew_cnt == 32'(TEW_CYC - 1));

	// State transitions of the receiver and engine.
	always_comb
	begin
		next_state = state;
		unique case (state)
			ewg_pkg::EWG_IDLE:
			begin
				// The start bit is a one on a rising serial clock.
				if (cs_s && sk_rise && di_s)
				begin
					next_state = ewg_pkg::EWG_SHIFT;
				end
			end
			ewg_pkg::EWG_SHIFT:
			begin
				if (!cs_s)
				begin
					next_state = (armed_op != ewg_pkg::EWG_OP_NONE) ? ewg_pkg::EWG_BUSY
						: ewg_pkg::EWG_IDLE; // [R7] [R10]
				end
			end
			ewg_pkg::EWG_ARMED:
			begin
				next_state = ewg_pkg::EWG_IDLE;
			end
			ewg_pkg::EWG_BUSY:
			begin
				// Runs off the system clock only. [R12]
				if (tew_end && (sweep == '1))
				begin
					next_state = ewg_pkg::EWG_IDLE;
				end
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= ewg_pkg::EWG_IDLE;
		end
		else if (ce)
		begin
			state <= next_state;
		end
	end

	// Shift in bits and arm the bulk operation at frame end.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			shreg     <= '0;
			bit_cnt   <= 5'h00;
			armed_op  <= ewg_pkg::EWG_OP_NONE;
			unlocked  <= 1'b0; // [R1]
			fill_word <= '0;
			cs_prev   <= 1'b0;
			sk_prev   <= 1'b0;
		end
		else if (ce)
		begin
			cs_prev <= cs_s;
			sk_prev <= sk_s;
			if (state == ewg_pkg::EWG_IDLE)
			begin
				bit_cnt  <= 5'h00;
				armed_op <= ewg_pkg::EWG_OP_NONE;
			end
			else if (state == ewg_pkg::EWG_SHIFT && cs_s && sk_rise
				&& bit_cnt != 5'(`EWG_FRAME_BITS))
			begin
				shreg   <= {shreg[`EWG_FRAME_BITS-2:0], di_s};
				bit_cnt <= bit_cnt + 5'h01;
			end
			else if (state == ewg_pkg::EWG_SHIFT && is_ext)
			begin
				// Lock and unlock ignore the enable pin. [R15]
				if (ext == `EWG_EXT_UNLOCK)
				begin
					unlocked <= 1'b1; // [R3]
				end
				else if (ext == `EWG_EXT_LOCK)
				begin
					unlocked <= 1'b0; // [R3]
				end
				else if (ext == `EWG_EXT_BCLEAR && may_write)
				begin
					armed_op  <= ewg_pkg::EWG_OP_CLEAR;
					fill_word <= '1; // [R8]
				end
			end
			else if (state == ewg_pkg::EWG_SHIFT && is_bprog && may_write)
			begin
				armed_op  <= ewg_pkg::EWG_OP_PROG;
				fill_word <= shreg[DATA_W-1:0]; // [R11]
			end
		end
	end

	// ======================================================================
	// Self-timed bulk engine
	// ======================================================================

	// Count the pulse, then sweep every word in one stretch at its end.
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tew_cnt <= 32'h0000_0000;
			sweep   <= '0;
		end
		else if (ce)
		begin
			if (state != ewg_pkg::EWG_BUSY)
			begin
				tew_cnt <= 32'h0000_0000;
				sweep   <= '0;
			end
			else if (!tew_end)
			begin
				tew_cnt <= tew_cnt + 32'h0000_0001;
			end
			else
			begin
				sweep <= sweep + 1'b1;
			end
		end
	end

	// Every location gets the fill word, whatever it held. [R7] [R10] [R11]
	wire arr_wr = (state == ewg_pkg::EWG_BUSY) && tew_end;

	// Storage array; reads do not look at the latch. [R5]
	ewg_array #(
		.ADDR_W (ADDR_W),
		.DATA_W (DATA_W)
	) u_array (
		.clk     (clk),
		.ce      (ce),
		.wr_en   (arr_wr),
		.wr_addr (sweep),
		.wr_data (fill_word),
		.rd_addr (peek_addr),
		.rd_data (peek_data)
	);

	// ======================================================================
	// Status output
	// ======================================================================

	// Status is driven while selected and idle or busy; low is busy. [R13] [R14] [R18]
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			serial_data_out <= 1'b0;
			serial_data_oe  <= 1'b0;
		end
		else if (ce)
		begin
			serial_data_out <= (state != ewg_pkg::EWG_BUSY); // [R14]
			serial_data_oe  <= cs_s && (state != ewg_pkg::EWG_SHIFT); // [R13]
		end
	end

	// Visible latch and engine state.
	assign write_unlocked = unlocked;
	assign bulk_busy      = (state == ewg_pkg::EWG_BUSY);

endmodule // ewg_guard

// File: ewg_guard_properties.sv
`timescale 1ns/1ps
`include "ewg_defs.svh"
// ==========================================================================
// Port checks for the write guard and bulk engine.
// ==========================================================================
module ewg_guard_properties #(
	parameter int TEW_CYC = `EWG_TEW_CYC
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic chip_select,
	input wire logic program_enable_input,
	input wire logic serial_data_out,
	input wire logic serial_data_oe,
	input wire logic write_unlocked,
	input wire logic bulk_busy
);
	int cnt; // Cycles spent in the current bulk cycle.
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Counts busy cycles so the self-timed length can be bounded.
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			cnt <= 0;
		else
			cnt <= bulk_busy ? cnt + 1 : 0;
	a_reset_locked: assert property ($rose(rst_b) |-> !write_unlocked)
		else $error("latch open after reset");
	a_busy_reads_low: assert property (bulk_busy && $past(bulk_busy) && serial_data_oe |-> !serial_data_out)
		else $error("status not busy");
	a_idle_reads_high: assert property (!bulk_busy && !$past(bulk_busy) && serial_data_oe |-> serial_data_out)
		else $error("status not ready");
	a_oe_needs_select: assert property (!chip_select [*6] |-> !serial_data_oe)
		else $error("output driven while deselected");
	a_bulk_needs_unlock: assert property ($rose(bulk_busy) |-> write_unlocked)
		else $error("bulk cycle while locked");
	a_bulk_needs_pe: assert property (!program_enable_input [*8] |-> !$rose(bulk_busy))
		else $error("bulk cycle with enable low");
	a_start_after_fall: assert property ($rose(bulk_busy) |-> !$past(chip_select, 2))
		else $error("bulk cycle started while selected");
	a_latch_needs_frame: assert property ($changed(write_unlocked) |-> $past(chip_select, 3))
		else $error("latch changed outside a frame");
	a_busy_full_len: assert property ($fell(bulk_busy) |-> cnt >= TEW_CYC)
		else $error("bulk cycle too short");
	c_bulk: cover property ($rose(bulk_busy));
	c_unlock: cover property ($rose(write_unlocked));
	c_poll_busy: cover property (serial_data_oe && !serial_data_out);
endmodule // ewg_guard_properties

bind ewg_guard ewg_guard_properties #(.TEW_CYC(TEW_CYC)) u_chk (
	.clk                  (clk),
	.rst_b                (rst_b),
	.chip_select          (chip_select),
	.program_enable_input (program_enable_input),
	.serial_data_out      (serial_data_out),
	.serial_data_oe       (serial_data_oe),
	.write_unlocked       (write_unlocked),
	.bulk_busy            (bulk_busy)
);

// File: ewg_host.sv
`timescale 1ns/1ps
// ==========================================================================
// Host model: frames instructions and polls the status output.
// ==========================================================================
module ewg_host (
	input  wire logic clk,
	input  wire logic serial_data_out,
	input  wire logic serial_data_oe,
	output logic      chip_select,
	output logic      serial_clock_in,
	output logic      serial_data_in,
	output logic      program_enable_input
);
	// Deselect time held after every frame and poll: 1 us at 8 ns, enough for the slowest grade.
	localparam int CS_LOW_CYC = 125;
	// Serial clock stands low and the device is deselected at start.
	initial
	begin
		chip_select = 1'b0;
		serial_clock_in = 1'b0;
		serial_data_in = 1'b0;
		program_enable_input = 1'b1;
	end
	// Waits n edges, then steps just past the edge.
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Sets the enable pin level.
	task automatic set_pe(input logic v);
		program_enable_input = v;
	endtask
	// Sends n bits MSB first, four clocks a phase, then deselects.
	task automatic send(input logic [28:0] bits, input int n);
		tick(1);
		chip_select = 1'b1;
		for (int i = n - 1; i >= 0; i--)
		begin
			serial_data_in = bits[i];
			tick(4);
			serial_clock_in = 1'b1;
			tick(4);
			serial_clock_in = 1'b0;
		end
		tick(4);
		chip_select = 1'b0;
		serial_data_in = ~serial_data_in; // Released line no longer shows its value.
		tick(CS_LOW_CYC);
	endtask
	// Selects without clocking and samples the status output.
	task automatic poll(output logic oe, output logic dout);
		chip_select = 1'b1;
		tick(6);
		oe = serial_data_oe;
		dout = serial_data_out;
		chip_select = 1'b0;
		tick(CS_LOW_CYC);
	endtask
endmodule // ewg_host

// File: ewg_pkg.sv
package ewg_pkg;

	// Receiver and bulk engine states.
	typedef enum logic [1:0] {
		EWG_IDLE,
		EWG_SHIFT,
		EWG_ARMED,
		EWG_BUSY
	} ewg_state_t;

	// Kinds of bulk work that may be armed.
	typedef enum logic [1:0] {
		EWG_OP_NONE,
		EWG_OP_CLEAR,
		EWG_OP_PROG
	} ewg_op_t;

endpackage
